// ==== design/ctb_pkg.sv ====
// Constants and types shared by the core trim register bank
package ctb_pkg;

   // ************************************************************
   // Register bus geometry
   // ************************************************************
   localparam int CTB_ADDR_W = 12;
   localparam int CTB_DATA_W = 16;
   localparam int CTB_NUM_REGS = 5;
   localparam int CTB_IDX_W = 3;

   // ************************************************************
   // Register indices into the trim store
   // ************************************************************
   localparam logic [2:0] CTB_IDX_B_TIM_SA = 3'h0;
   localparam logic [2:0] CTB_IDX_A_TIM_SB = 3'h1;
   localparam logic [2:0] CTB_IDX_B_TIM_SB = 3'h2;
   localparam logic [2:0] CTB_IDX_A_OFS_DA = 3'h3;
   localparam logic [2:0] CTB_IDX_A_OFS_DB = 3'h4;
   localparam logic [2:0] CTB_IDX_MISS = 3'h7;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [11:0] CTB_OFS_B_TIM_SA = 12'h315;
   localparam logic [11:0] CTB_OFS_A_TIM_SB = 12'h31A;
   localparam logic [11:0] CTB_OFS_B_TIM_SB = 12'h31B;
   localparam logic [11:0] CTB_OFS_A_OFS_DA = 12'h344;
   localparam logic [11:0] CTB_OFS_A_OFS_DB = 12'h346;
   localparam logic [11:0] CTB_OFS_STATUS = 12'h3F0;

   // ************************************************************
   // Field layout and reset values
   // ************************************************************
   localparam logic [15:0] CTB_MASK_TIMING = 16'h00FF;
   localparam logic [15:0] CTB_MASK_OFFSET = 16'hFFFF;
   localparam int CTB_TIMING_W = 8;
   localparam int CTB_OFFSET_W = 12;
   localparam logic [15:0] CTB_TRIM_RESET = 16'h0000;
   localparam int CTB_ST_FUSE_DONE = 0;
   localparam int CTB_ST_A_TIM_VAL = 1;
   localparam int CTB_ST_B_TIM_VAL = 2;
   localparam int CTB_ST_A_OFS_VAL = 3;

   // ************************************************************
   // Load sequencer states
   // ************************************************************
   typedef enum logic {
      CTB_LOAD,
      CTB_RUN
   } ctb_state_type;

endpackage : ctb_pkg

// ==== design/ctb_core_trim_bank.sv ====
// Trim register bank for the two interleaved converter cores
//
// Local design decision: strobed register access.
`timescale 1ns/100ps

module ctb_core_trim_bank
   import ctb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [CTB_ADDR_W-1:0] reg_addr,
   input wire logic [CTB_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CTB_DATA_W-1:0] reg_rdata,
   input wire logic fuse_valid,
   input wire logic [CTB_NUM_REGS-1:0][CTB_DATA_W-1:0] fuse_trim,
   input wire logic dual_mode,
   input wire logic input_sel_b,
   input wire logic fg_cal_en,
   output logic fuse_done,
   output logic [CTB_TIMING_W-1:0] core_a_timing,
   output logic [CTB_TIMING_W-1:0] core_b_timing,
   output logic [CTB_OFFSET_W-1:0] core_a_offset,
   output logic core_a_timing_valid,
   output logic core_b_timing_valid,
   output logic core_a_offset_valid
);

   // ************************************************************
   // Address decode and field masks
   // ************************************************************

   // Maps a bus address onto a trim store index
   // Unmapped addresses give the miss index, so reads other than the status word return zero and writes drop
   function automatic logic [CTB_IDX_W-1:0] ctb_decode(
      input logic [CTB_ADDR_W-1:0] addr
   );
      logic [CTB_IDX_W-1:0] idx;
      idx = CTB_IDX_MISS;
      case (addr)
         CTB_OFS_B_TIM_SA: idx = CTB_IDX_B_TIM_SA;
         CTB_OFS_A_TIM_SB: idx = CTB_IDX_A_TIM_SB;
         CTB_OFS_B_TIM_SB: idx = CTB_IDX_B_TIM_SB;
         CTB_OFS_A_OFS_DA: idx = CTB_IDX_A_OFS_DA;
         CTB_OFS_A_OFS_DB: idx = CTB_IDX_A_OFS_DB;
         default: idx = CTB_IDX_MISS;
      endcase
      return idx;
   endfunction : ctb_decode

   // Storable bits of each register; timing trims hold 8 bits
   // Reserved offset bits 15:12 stay writable and read back as written
   function automatic logic [CTB_DATA_W-1:0] ctb_mask(
      input int idx
   );
      logic [CTB_DATA_W-1:0] m;
      m = CTB_MASK_OFFSET;
      if (idx < int'(CTB_IDX_A_OFS_DA)) begin
         m = CTB_MASK_TIMING;
      end
      return m;
   endfunction : ctb_mask

   // ************************************************************
   // State
   // ************************************************************
   // Load sequencer
   ctb_state_type state_reg;
   ctb_state_type state_next;

   // Trim store, one word per register
   logic [CTB_NUM_REGS-1:0][CTB_DATA_W-1:0] trim_reg;
   logic [CTB_NUM_REGS-1:0][CTB_DATA_W-1:0] trim_next;

   // Read data
   logic [CTB_DATA_W-1:0] rdata_reg;
   logic [CTB_DATA_W-1:0] rdata_next;

   // Decoded bus address
   logic [CTB_IDX_W-1:0] wr_idx;
   logic [CTB_IDX_W-1:0] rd_idx;

   // Registered routing outputs and their valid flags
   logic [CTB_TIMING_W-1:0] a_tim_reg;
   logic [CTB_TIMING_W-1:0] a_tim_next;
   logic [CTB_TIMING_W-1:0] b_tim_reg;
   logic [CTB_TIMING_W-1:0] b_tim_next;
   logic [CTB_OFFSET_W-1:0] a_ofs_reg;
   logic [CTB_OFFSET_W-1:0] a_ofs_next;
   logic [2:0] valid_reg;
   logic [2:0] valid_next;

   assign wr_idx = ctb_decode(reg_addr);
   assign rd_idx = ctb_decode(reg_addr);

   // ************************************************************
   // Bus and mode qualifiers
   // ************************************************************

   // Fuse copy fires once, on the first edge in load state that sees fuse data
   logic load_fire;
   // Software writes count only in run state, so the fuse copy never meets them
   logic wr_fire;
   // Read strobes aimed at a trim register or at the status word
   logic rd_trim_hit;
   logic rd_status_hit;
   // Calibration combinations that own a register in this bank
   logic sel_single_a;
   logic sel_single_b;
   logic sel_dual_a;
   logic sel_dual_b;
   // Status word as software reads it
   logic [CTB_DATA_W-1:0] status_word;

   // Strobe qualifiers; the miss index keeps unmapped writes out of the store
   // Reads need no load gate: before the copy the store reads as zero
   assign load_fire = (state_reg == CTB_LOAD) && fuse_valid;
   assign wr_fire = (state_reg == CTB_RUN) && reg_wr && (wr_idx != CTB_IDX_MISS);
   assign rd_trim_hit = reg_rd && (rd_idx != CTB_IDX_MISS);
   assign rd_status_hit = reg_rd && (reg_addr == CTB_OFS_STATUS);

   // Mode decode; calibration off selects nothing at all
   // The pair select only matters while calibration is on
   assign sel_single_a = fg_cal_en && !dual_mode && !input_sel_b;
   assign sel_single_b = fg_cal_en && !dual_mode && input_sel_b;
   assign sel_dual_a = fg_cal_en && dual_mode && !input_sel_b;
   assign sel_dual_b = fg_cal_en && dual_mode && input_sel_b;

   // ************************************************************
   // Fuse load sequencer and register writes
   // ************************************************************

   // Load sequencer: waits once per reset for valid fuse data
   // A second fuse strobe after the copy is ignored until the next reset
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CTB_LOAD: begin
            if (load_fire) begin
               state_next = CTB_RUN;
            end
         end
         CTB_RUN: begin
            state_next = CTB_RUN;
         end
         default: begin
            state_next = CTB_LOAD;
         end
      endcase
   end

   // Load sequencer state
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= CTB_LOAD;
      end else begin
         state_reg <= state_next;
      end
   end

   // Trim store: fuse copy first, software writes only afterwards
   // Copy and write never meet in one cycle, as writes need the run state
   always_comb begin
      trim_next = trim_reg;
      if (load_fire) begin
         for (int i = 0; i < CTB_NUM_REGS; i++) begin
            trim_next[i] = fuse_trim[i] & ctb_mask(i);
         end
      end else if (wr_fire) begin
         // Factory values may be overwritten
         trim_next[wr_idx] = reg_wdata & ctb_mask(int'(wr_idx));
      end
   end

   // Trim store; zero only until the fuse copy lands
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_reg <= {CTB_NUM_REGS{CTB_TRIM_RESET}};
      end else begin
         trim_reg <= trim_next;
      end
   end

   // ************************************************************
   // Status word
   // ************************************************************

   // Load flag and the three routing flags; other bits read zero
   always_comb begin
      status_word = '0;
      status_word[CTB_ST_FUSE_DONE] = (state_reg == CTB_RUN);
      status_word[CTB_ST_A_TIM_VAL] = valid_reg[0];
      status_word[CTB_ST_B_TIM_VAL] = valid_reg[1];
      status_word[CTB_ST_A_OFS_VAL] = valid_reg[2];
   end

   // ************************************************************
   // Read port
   // ************************************************************

   // Read data stands only in the cycle after the strobe
   // Unmapped reads give zero, so software can probe safely
   always_comb begin
      rdata_next = '0;
      if (rd_trim_hit) begin
         rdata_next = trim_reg[rd_idx];
      end else if (rd_status_hit) begin
         rdata_next = status_word;
      end
   end

   // Read data register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ************************************************************
   // Trim routing to the cores
   // ************************************************************

   // Core A timing: only single mode on pair B owns a register here
   // Outputs are registered, so a mode change shows one cycle later
   always_comb begin
      a_tim_next = '0;
      if (sel_single_b) begin
         a_tim_next = trim_reg[CTB_IDX_A_TIM_SB][CTB_TIMING_W-1:0];
      end
   end

   // Core B timing: single mode, one register per input pair
   always_comb begin
      b_tim_next = '0;
      if (sel_single_a) begin
         b_tim_next = trim_reg[CTB_IDX_B_TIM_SA][CTB_TIMING_W-1:0];
      end else if (sel_single_b) begin
         b_tim_next = trim_reg[CTB_IDX_B_TIM_SB][CTB_TIMING_W-1:0];
      end
   end

   // Core A offset: dual mode, bits 11:0 of the pair's register
   // Reserved bits 15:12 never reach the core
   always_comb begin
      a_ofs_next = '0;
      if (sel_dual_a) begin
         a_ofs_next = trim_reg[CTB_IDX_A_OFS_DA][CTB_OFFSET_W-1:0];
      end else if (sel_dual_b) begin
         a_ofs_next = trim_reg[CTB_IDX_A_OFS_DB][CTB_OFFSET_W-1:0];
      end
   end

   // Valid flags; a low flag means its output is held at zero
   // The status word mirrors these same flags
   always_comb begin
      valid_next[0] = sel_single_b;
      valid_next[1] = sel_single_a || sel_single_b;
      valid_next[2] = sel_dual_a || sel_dual_b;
   end

   // Registered trim outputs
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         a_tim_reg <= '0;
         b_tim_reg <= '0;
         a_ofs_reg <= '0;
         valid_reg <= 3'h0;
      end else begin
         a_tim_reg <= a_tim_next;
         b_tim_reg <= b_tim_next;
         a_ofs_reg <= a_ofs_next;
         valid_reg <= valid_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Read data and load flag
   assign reg_rdata = rdata_reg;
   assign fuse_done = (state_reg == CTB_RUN);

   // Trim values to the converter cores, zero while not selected
   assign core_a_timing = a_tim_reg;
   assign core_b_timing = b_tim_reg;
   assign core_a_offset = a_ofs_reg;

   // Routing flags, straight from their registers
   assign core_a_timing_valid = valid_reg[0];
   assign core_b_timing_valid = valid_reg[1];
   assign core_a_offset_valid = valid_reg[2];

endmodule : ctb_core_trim_bank

// ==== tb/ctb_core_trim_bank_assertions.sv ====
// Port-level checks for the core trim register bank
`timescale 1ns/100ps
module ctb_core_trim_bank_assertions
   import ctb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [CTB_ADDR_W-1:0] reg_addr,
   input wire logic [CTB_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [CTB_DATA_W-1:0] reg_rdata,
   input wire logic fuse_valid,
   input wire logic [CTB_NUM_REGS-1:0][CTB_DATA_W-1:0] fuse_trim,
   input wire logic dual_mode,
   input wire logic input_sel_b,
   input wire logic fg_cal_en,
   input wire logic fuse_done,
   input wire logic [CTB_TIMING_W-1:0] core_a_timing,
   input wire logic [CTB_TIMING_W-1:0] core_b_timing,
   input wire logic [CTB_OFFSET_W-1:0] core_a_offset,
   input wire logic core_a_timing_valid,
   input wire logic core_b_timing_valid,
   input wire logic core_a_offset_valid
);
   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_read_one_cycle: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
      else $error("read data outside its slot");
   a_timing_high_zero: assert property (reg_rd && reg_addr inside {12'h315, 12'h31A, 12'h31B}
      |=> reg_rdata[15:8] == 8'h00) else $error("timing trim upper byte set");
   a_cal_off_quiet: assert property (!$past(fg_cal_en) |-> core_a_timing == 8'h00
      && core_b_timing == 8'h00 && core_a_offset == 12'h000
      && !core_a_timing_valid && !core_b_timing_valid && !core_a_offset_valid)
      else $error("trim routed with calibration off");
   a_single_a_route: assert property (fg_cal_en && !dual_mode && !input_sel_b && fuse_done
      |=> core_b_timing_valid && !core_a_timing_valid && !core_a_offset_valid)
      else $error("single pair A routing wrong");
   a_single_b_route: assert property (fg_cal_en && !dual_mode && input_sel_b && fuse_done
      |=> core_a_timing_valid && core_b_timing_valid && !core_a_offset_valid)
      else $error("single pair B routing wrong");
   a_dual_route: assert property (fg_cal_en && dual_mode && fuse_done
      |=> core_a_offset_valid && !core_a_timing_valid && !core_b_timing_valid)
      else $error("dual mode routing wrong");
   a_fuse_sticky: assert property (fuse_done |=> fuse_done)
      else $error("load flag dropped");
   a_fuse_cause: assert property ($rose(fuse_done) |-> $past(fuse_valid))
      else $error("load without fuse data");
   a_write_to_core: assert property (reg_wr && fuse_done && reg_addr == 12'h315
      && fg_cal_en && !dual_mode && !input_sel_b ##1 fg_cal_en && !dual_mode && !input_sel_b
      |=> core_b_timing == $past(reg_wdata[7:0], 2)) else $error("written trim not routed");
endmodule : ctb_core_trim_bank_assertions

bind ctb_core_trim_bank ctb_core_trim_bank_assertions u_chk (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .fuse_valid(fuse_valid),
   .fuse_trim(fuse_trim),
   .dual_mode(dual_mode),
   .input_sel_b(input_sel_b),
   .fg_cal_en(fg_cal_en),
   .fuse_done(fuse_done),
   .core_a_timing(core_a_timing),
   .core_b_timing(core_b_timing),
   .core_a_offset(core_a_offset),
   .core_a_timing_valid(core_a_timing_valid),
   .core_b_timing_valid(core_b_timing_valid),
   .core_a_offset_valid(core_a_offset_valid)
);

// ==== tb/ctb_core_trim_bank_tb.sv ====
// Self-checking bench for the core trim register bank
`timescale 1ns/100ps
module ctb_core_trim_bank_tb
   import ctb_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [CTB_ADDR_W-1:0] reg_addr = '0;
   logic [CTB_DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic fuse_valid = 1'b0;
   logic [CTB_NUM_REGS-1:0][CTB_DATA_W-1:0] fuse_trim = '0;
   logic dual_mode = 1'b0;
   logic input_sel_b = 1'b0;
   logic fg_cal_en = 1'b0;
   logic [CTB_DATA_W-1:0] reg_rdata;
   logic fuse_done, core_a_timing_valid, core_b_timing_valid, core_a_offset_valid;
   logic [CTB_TIMING_W-1:0] core_a_timing, core_b_timing;
   logic [CTB_OFFSET_W-1:0] core_a_offset;
   logic [15:0] mdl [5];
   logic [11:0] adr [5] = '{12'h315, 12'h31A, 12'h31B, 12'h344, 12'h346};
   logic [15:0] exp_q [$];
   logic rd_d = 1'b0;
   int err_count = 0;
   int n_compared = 0;
   integer seed = 67545;

   // ************************************************************
   // Clock, device and read monitor
   // ************************************************************
   always #10 sys_clk = ~sys_clk;
   ctb_core_trim_bank u_dut (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .fuse_valid(fuse_valid),
      .fuse_trim(fuse_trim),
      .dual_mode(dual_mode),
      .input_sel_b(input_sel_b),
      .fg_cal_en(fg_cal_en),
      .fuse_done(fuse_done),
      .core_a_timing(core_a_timing),
      .core_b_timing(core_b_timing),
      .core_a_offset(core_a_offset),
      .core_a_timing_valid(core_a_timing_valid),
      .core_b_timing_valid(core_b_timing_valid),
      .core_a_offset_valid(core_a_offset_valid)
   );
   // Read data is due one cycle after the strobe
   always @(posedge sys_clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         if (exp_q.size() == 0) err_count++;
         else chk(reg_rdata, exp_q.pop_front());
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [15:0] msk(input int i);
      return (i < 3) ? CTB_MASK_TIMING : CTB_MASK_OFFSET;
   endfunction : msk
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
   endtask : wr
   task rd(input logic [11:0] a, input logic [15:0] e);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge sys_clk);
   endtask : rd
   task idle(input int n);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask : idle
   // Sets the mode inputs and compares all routed outputs
   task route(input logic f, input logic d, input logic s);
      logic [30:0] e;
      fg_cal_en <= f;
      dual_mode <= d;
      input_sel_b <= s;
      idle(2);
      e = '0;
      if (f && !d) e = s ? {3'h6, mdl[1][7:0], mdl[2][7:0], 12'h000}
         : {3'h2, 8'h00, mdl[0][7:0], 12'h000};
      if (f && d) e = {3'h1, 16'h0000, s ? mdl[4][11:0] : mdl[3][11:0]};
      chk({core_a_timing_valid, core_b_timing_valid, core_a_offset_valid, core_a_timing,
         core_b_timing, core_a_offset}, e);
   endtask : route
   task conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      idle(2);
      wr(12'h315, 16'h00A5);
      for (int i = 0; i < 5; i++) rd(adr[i], 16'h0000);
      idle(2);
      $display("test pre-load done");
      for (int i = 0; i < 5; i++) begin
         mdl[i] = 16'($random(seed));
         fuse_trim[i] <= mdl[i];
         mdl[i] = mdl[i] & msk(i);
      end
      fuse_valid <= 1'b1;
      idle(1);
      fuse_valid <= 1'b0;
      for (int k = 0; k < 20 && fuse_done !== 1'b1; k++) @(posedge sys_clk);
      if (fuse_done !== 1'b1) begin
         err_count++;
      end
      for (int i = 0; i < 5; i++) rd(adr[i], mdl[i]);
      wr(12'h316, 16'hFFFF);
      rd(12'h316, 16'h0000);
      rd(12'h3F0, 16'h0001);
      $display("test fuse load done");
      for (int i = 0; i < 5; i++) begin
         mdl[i] = 16'($random(seed));
         wr(adr[i], mdl[i]);
         mdl[i] = mdl[i] & msk(i);
      end
      for (int i = 0; i < 5; i++) rd(adr[i], mdl[i]);
      idle(2);
      $display("test write readback done");
      for (int c = 0; c < 8; c++) route(c[2], c[1], c[0]);
      route(1'b1, 1'b0, 1'b0);
      wr(12'h315, 16'h003C);
      idle(2);
      chk(core_b_timing, 8'h3C);
      rd(12'h3F0, 16'h0005);
      idle(2);
      $display("test routing done");
      conclude();
   end
endmodule : ctb_core_trim_bank_tb
